// >>> design/obt_fifo.sv
// obt_fifo: synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
module obt_fifo #(
   parameter int unsigned WIDTH = obt_pkg::LOG_W,
   parameter int unsigned DEPTH = obt_pkg::LOG_DEPTH
) (
   input  wire logic                         clk,
   input  wire logic                         rst_n,
   input  wire logic                         ce,
   input  wire logic                         in_valid,
   output logic                              in_ready,
   input  wire logic [WIDTH-1:0]             in_data,
   output logic                              out_valid,
   input  wire logic                         out_ready,
   output logic [WIDTH-1:0]                  out_data,
   output logic [obt_pkg::LOG_CNT_W-1:0]     level
);
   import obt_pkg::*;

   logic [WIDTH-1:0]     mem [DEPTH];
   logic [LOG_PTR_W-1:0] wr_q;
   logic [LOG_PTR_W-1:0] rd_q;
   logic [LOG_CNT_W-1:0] cnt_q;
   logic [LOG_CNT_W-1:0] cnt_d;
   wire                  push;
   wire                  pop;

   function automatic logic [LOG_PTR_W-1:0] ptr_next(input logic [LOG_PTR_W-1:0] p);
      ptr_next = (p == LOG_PTR_W'(DEPTH - 1)) ? PTR_RST : p + PTR_ONE;
   endfunction

   // ************************************************************
   // handshake
   // ************************************************************
   assign in_ready  = (cnt_q != LOG_CNT_W'(DEPTH));
   assign out_valid = (cnt_q != CNT_RST);
   assign push      = ce & in_valid & in_ready;
   assign pop       = ce & out_valid & out_ready;
   assign out_data  = mem[rd_q];
   assign level     = cnt_q;

   always_comb begin
      cnt_d = cnt_q;
      if (push && !pop) begin
         cnt_d = cnt_q + CNT_ONE;
      end else if (pop && !push) begin
         cnt_d = cnt_q - CNT_ONE;
      end
   end

   // ************************************************************
   // storage
   // ************************************************************
   // data array has no reset; only words behind a valid count are read
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q  <= PTR_RST;
         rd_q  <= PTR_RST;
         cnt_q <= CNT_RST;
      end else begin
         if (push) begin
            wr_q <= ptr_next(wr_q);
         end
         if (pop) begin
            rd_q <= ptr_next(rd_q);
         end
         cnt_q <= cnt_d;
      end
   end

endmodule

// >>> design/obt_transceiver.sv
// obt_transceiver: octal registered bus transceiver between ports a and b
`timescale 1ns/10ps
module obt_transceiver (
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   input  wire logic                          ce,
   input  wire logic [obt_pkg::DATA_W-1:0]    a_port_in,
   output logic      [obt_pkg::DATA_W-1:0]    a_port_out,
   output logic                               a_port_oe_n,
   input  wire logic [obt_pkg::DATA_W-1:0]    b_port_in,
   output logic      [obt_pkg::DATA_W-1:0]    b_port_out,
   output logic                               b_port_oe_n,
   input  wire logic                          a_capture_clock,
   input  wire logic                          b_capture_clock,
   input  wire logic                          a_drive_enable_n,
   input  wire logic                          b_drive_enable,
   input  wire logic                          a_source_select,
   input  wire logic                          b_source_select,
   output logic      [obt_pkg::DATA_W-1:0]    a_stored_value,
   output logic      [obt_pkg::DATA_W-1:0]    b_stored_value,
   output logic                               a_stored_valid,
   output logic                               b_stored_valid,
   output logic                               a_captured,
   output logic                               b_captured,
   output obt_pkg::obt_mode_e                 bus_mode,
   output logic                               log_valid,
   input  wire logic                          log_ready,
   output logic      [obt_pkg::LOG_W-1:0]     log_data,
   output logic      [obt_pkg::LOG_CNT_W-1:0] log_level,
   output logic                               log_in_ready,
   output logic                               log_overflow,
   input  wire logic                          log_overflow_clear
);
   import obt_pkg::*;

   // ************************************************************
   // declarations
   // ************************************************************
   logic [DATA_W-1:0] a_reg_q;
   logic [DATA_W-1:0] b_reg_q;
   logic              a_seen_q;
   logic              b_seen_q;
   logic              a_clk_prev_q;
   logic              b_clk_prev_q;
   logic              a_cap_pulse_q;
   logic              b_cap_pulse_q;
   logic [DATA_W-1:0] a_out_q;
   logic [DATA_W-1:0] b_out_q;
   logic [DATA_W-1:0] a_out_d;
   logic [DATA_W-1:0] b_out_d;
   logic              a_oe_n_q;
   logic              b_oe_n_q;
   obt_mode_e         mode_q;
   obt_mode_e         mode_d;
   logic              overflow_q;
   logic              overflow_d;

   wire               a_cap_edge;
   wire               b_cap_edge;
   wire [DATA_W-1:0]  a_stored_safe;
   wire [DATA_W-1:0]  b_stored_safe;
   wire               a_drive_req;
   wire               b_drive_req;
   wire               log_push;
   wire [LOG_W-1:0]   log_word;
   wire               fifo_in_ready;
   wire               log_drop;

   // ************************************************************
   // functions
   // ************************************************************
   // one rising-edge detector shape for both capture clocks
   function automatic logic rise(input logic now, input logic prev);
      rise = now & ~prev;
   endfunction

   // source mux shared by both directions
   function automatic logic [DATA_W-1:0] pick_source(
      input logic              sel,
      input logic [DATA_W-1:0] live,
      input logic [DATA_W-1:0] stored
   );
      pick_source = (sel == SEL_STORED) ? stored : live;
   endfunction

   // stored value shown as zero until the first capture, so no unknown leaks out
   function automatic logic [DATA_W-1:0] mask_unseen(
      input logic              seen,
      input logic [DATA_W-1:0] value
   );
      mask_unseen = seen ? value : DATA_RST;
   endfunction

   // ************************************************************
   // capture clock edge detection
   // ************************************************************
   // capture clocks are sampled as synchronous inputs of clk
   assign a_cap_edge = ce & rise(a_capture_clock, a_clk_prev_q);
   assign b_cap_edge = ce & rise(b_capture_clock, b_clk_prev_q);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         a_clk_prev_q <= FLAG_RST;
         b_clk_prev_q <= FLAG_RST;
      end else if (ce) begin
         a_clk_prev_q <= a_capture_clock;
         b_clk_prev_q <= b_capture_clock;
      end
   end

   // ************************************************************
   // storage registers
   // ************************************************************
   // no reset, hold
   always_ff @(posedge clk) begin
      if (a_cap_edge) begin
         a_reg_q <= a_port_in;
      end
   end

   always_ff @(posedge clk) begin
      if (b_cap_edge) begin
         b_reg_q <= b_port_in;
      end
   end

   // marks that each register holds a real captured word
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         a_seen_q <= FLAG_RST;
         b_seen_q <= FLAG_RST;
      end else begin
         if (a_cap_edge) begin
            a_seen_q <= 1'b1;
         end
         if (b_cap_edge) begin
            b_seen_q <= 1'b1;
         end
      end
   end

   assign a_stored_safe = mask_unseen(a_seen_q, a_reg_q);
   assign b_stored_safe = mask_unseen(b_seen_q, b_reg_q);

   // ************************************************************
   // source selection
   // ************************************************************
   // select live or stored
   assign a_out_d = pick_source(a_source_select, b_port_in, b_stored_safe);

   assign b_out_d = pick_source(b_source_select, a_port_in, a_stored_safe);

   // ************************************************************
   // drive enables
   // ************************************************************
   // enable polarities
   assign a_drive_req = (a_drive_enable_n == OE_N_DRIVE);
   assign b_drive_req = b_drive_enable;

   always_comb begin
      mode_d = OBT_ISOLATE;
      case ({a_drive_req, b_drive_req})
         2'b01: begin
            mode_d = OBT_A_TO_B;
         end
         2'b10: begin
            mode_d = OBT_B_TO_A;
         end
         2'b11: begin
            mode_d = OBT_BOTH_WAYS;
         end
         default: begin
            mode_d = OBT_ISOLATE;
         end
      endcase
   end

   // ************************************************************
   // port output stage
   // ************************************************************
   // the mux result is retimed, so a select change moves the whole word in
   // one clk edge; costs one cycle of latency on every path to the pins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         a_out_q  <= DATA_RST;
         b_out_q  <= DATA_RST;
         a_oe_n_q <= OE_N_RELEASE;
         b_oe_n_q <= OE_N_RELEASE;
         mode_q   <= OBT_ISOLATE;
      end else if (ce) begin
         a_out_q  <= a_out_d;
         b_out_q  <= b_out_d;
         a_oe_n_q <= a_drive_req ? OE_N_DRIVE : OE_N_RELEASE;
         b_oe_n_q <= b_drive_req ? OE_N_DRIVE : OE_N_RELEASE;
         mode_q   <= mode_d;
      end
   end

   assign a_port_out  = a_out_q;
   assign a_port_oe_n = a_oe_n_q;
   assign b_port_out  = b_out_q;
   assign b_port_oe_n = b_oe_n_q;
   assign bus_mode    = mode_q;

   // ************************************************************
   // dual-register load through a driven port
   // ************************************************************
   // b register takes driven b lines
   // a register takes driven a lines
   // both fall out of ungated capture plus the port loop above; the driven
   // side carries the opposite bus one clk later, so the far bus must be
   // steady for a cycle before the clocks rise
   // with a stored select, simultaneous edges load the old word instead

   // ************************************************************
   // capture status
   // ************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         a_cap_pulse_q <= FLAG_RST;
         b_cap_pulse_q <= FLAG_RST;
      end else if (ce) begin
         a_cap_pulse_q <= a_cap_edge;
         b_cap_pulse_q <= b_cap_edge;
      end
   end

   assign a_captured     = a_cap_pulse_q;
   assign b_captured     = b_cap_pulse_q;
   assign a_stored_value = a_stored_safe;
   assign b_stored_value = b_stored_safe;
   assign a_stored_valid = a_seen_q;
   assign b_stored_valid = b_seen_q;

   // ************************************************************
   // capture log
   // ************************************************************
   // every capture event is logged; a full log never stalls capture, it
   // drops the word and raises the sticky overflow instead
   assign log_push = a_cap_edge | b_cap_edge;

   assign log_word[LOG_A_LSB +: DATA_W] = a_port_in;
   assign log_word[LOG_B_LSB +: DATA_W] = b_port_in;
   assign log_word[LOG_A_FLAG]          = a_cap_edge;
   assign log_word[LOG_B_FLAG]          = b_cap_edge;

   assign log_drop     = log_push & ~fifo_in_ready;
   assign log_in_ready = fifo_in_ready;

   obt_fifo #(
      .WIDTH (LOG_W),
      .DEPTH (LOG_DEPTH)
   ) u_log (
      .clk       (clk),
      .rst_n     (rst_n),
      .ce        (ce),
      .in_valid  (log_push),
      .in_ready  (fifo_in_ready),
      .in_data   (log_word),
      .out_valid (log_valid),
      .out_ready (log_ready),
      .out_data  (log_data),
      .level     (log_level)
   );

   // a drop in the clear cycle keeps the flag set
   always_comb begin
      overflow_d = overflow_q;
      if (log_overflow_clear) begin
         overflow_d = FLAG_RST;
      end
      if (log_drop) begin
         overflow_d = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         overflow_q <= FLAG_RST;
      end else if (ce) begin
         overflow_q <= overflow_d;
      end
   end

   assign log_overflow = overflow_q;

endmodule

// >>> shared/obt_pkg.sv
// obt_pkg: constants, field layout and types shared by the octal bus transceiver files
package obt_pkg;

   // ************************************************************
   // widths and depths
   // ************************************************************
   localparam int unsigned DATA_W     = 8;
   localparam int unsigned LOG_DEPTH  = 8;
   localparam int unsigned LOG_W      = 2 * DATA_W + 2;
   localparam int unsigned LOG_PTR_W  = $clog2(LOG_DEPTH);
   localparam int unsigned LOG_CNT_W  = $clog2(LOG_DEPTH + 1);

   // ************************************************************
   // capture log word layout
   // ************************************************************
   localparam int unsigned LOG_A_LSB  = 0;
   localparam int unsigned LOG_B_LSB  = DATA_W;
   localparam int unsigned LOG_A_FLAG = 2 * DATA_W;
   localparam int unsigned LOG_B_FLAG = 2 * DATA_W + 1;

   // ************************************************************
   // select and enable encodings
   // ************************************************************
   localparam logic SEL_LIVE       = 1'b0;
   localparam logic SEL_STORED     = 1'b1;
   localparam logic OE_N_DRIVE     = 1'b0;
   localparam logic OE_N_RELEASE   = 1'b1;

   // ************************************************************
   // reset values and count constants
   // ************************************************************
   localparam logic [DATA_W-1:0]    DATA_RST     = 8'h00;
   localparam logic [LOG_W-1:0]     LOG_RST      = 18'h00000;
   localparam logic [LOG_PTR_W-1:0] PTR_RST      = 3'h0;
   localparam logic [LOG_CNT_W-1:0] CNT_RST      = 4'h0;
   localparam logic [LOG_PTR_W-1:0] PTR_ONE      = 3'h1;
   localparam logic [LOG_CNT_W-1:0] CNT_ONE      = 4'h1;
   localparam logic [LOG_CNT_W-1:0] CNT_FULL     = 4'h8;
   localparam logic                 FLAG_RST     = 1'b0;

   // ************************************************************
   // bus management modes
   // ************************************************************
   typedef enum logic [1:0] {
      OBT_ISOLATE,
      OBT_A_TO_B,
      OBT_B_TO_A,
      OBT_BOTH_WAYS
   } obt_mode_e;

endpackage

// >>> sim/obt_bus_agent.sv
// obt_bus_agent: other agents on buses a and b, with wire resolution
`timescale 1ns/10ps
module obt_bus_agent (
   input  wire logic                       clk,
   input  wire logic [obt_pkg::DATA_W-1:0] a_port_out,
   input  wire logic                       a_port_oe_n,
   input  wire logic [obt_pkg::DATA_W-1:0] b_port_out,
   input  wire logic                       b_port_oe_n,
   input  wire logic                       a_agent_en,
   input  wire logic [obt_pkg::DATA_W-1:0] a_agent_val,
   input  wire logic                       b_agent_en,
   input  wire logic [obt_pkg::DATA_W-1:0] b_agent_val,
   output logic      [obt_pkg::DATA_W-1:0] a_line,
   output logic      [obt_pkg::DATA_W-1:0] b_line
);
   import obt_pkg::*;
   // ************************************************************
   // wire resolution
   // ************************************************************
   logic [DATA_W-1:0] a_last_q;
   logic [DATA_W-1:0] b_last_q;
   // driven port seen by capture
   // device wins a clash; bench only clashes with equal values
   assign a_line = (a_port_oe_n == OE_N_DRIVE) ? a_port_out : (a_agent_en ? a_agent_val : ~a_last_q);
   assign b_line = (b_port_oe_n == OE_N_DRIVE) ? b_port_out : (b_agent_en ? b_agent_val : ~b_last_q);
   // floating lines toggle so a stale value never passes
   always_ff @(posedge clk) begin
      a_last_q <= a_line;
      b_last_q <= b_line;
   end
endmodule

// >>> sim/obt_transceiver_checker.sv
// obt_transceiver_checker: port assertions for the octal transceiver
`timescale 1ns/10ps
module obt_transceiver_checker (
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   input  wire logic                       ce,
   input  wire logic [obt_pkg::DATA_W-1:0] a_port_in,
   input  wire logic [obt_pkg::DATA_W-1:0] a_port_out,
   input  wire logic                       a_port_oe_n,
   input  wire logic [obt_pkg::DATA_W-1:0] b_port_in,
   input  wire logic [obt_pkg::DATA_W-1:0] b_port_out,
   input  wire logic                       b_port_oe_n,
   input  wire logic                       a_capture_clock,
   input  wire logic                       b_capture_clock,
   input  wire logic                       a_drive_enable_n,
   input  wire logic                       b_drive_enable,
   input  wire logic                       a_source_select,
   input  wire logic                       b_source_select,
   input  wire logic [obt_pkg::DATA_W-1:0] a_stored_value,
   input  wire logic [obt_pkg::DATA_W-1:0] b_stored_value,
   input  wire logic                       a_captured,
   input  wire logic                       b_captured
);
   import obt_pkg::*;
   default clocking dcb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ************************************************************
   // capture edge tracking
   // ************************************************************
   logic a_cc_q;
   logic b_cc_q;
   wire  a_edge = ce && a_capture_clock && !a_cc_q;
   wire  b_edge = ce && b_capture_clock && !b_cc_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         a_cc_q <= 1'b0;
         b_cc_q <= 1'b0;
      end else if (ce) begin
         a_cc_q <= a_capture_clock;
         b_cc_q <= b_capture_clock;
      end
   end
   // ************************************************************
   // assertions
   // ************************************************************
   a_a_drive_gate: assert property (ce |=> a_port_oe_n == $past(a_drive_enable_n))
      else $error("a port drive enable wrong");
   a_b_drive_gate: assert property (ce |=> b_port_oe_n == !$past(b_drive_enable))
      else $error("b port drive enable wrong");
   a_a_live_path: assert property (ce && !a_drive_enable_n && a_source_select == SEL_LIVE |=>
      a_port_out == $past(b_port_in)) else $error("a port live data wrong");
   a_a_stored_path: assert property (ce && !a_drive_enable_n && a_source_select == SEL_STORED |=>
      a_port_out == $past(b_stored_value)) else $error("a port stored data wrong");
   a_b_live_path: assert property (ce && b_drive_enable && b_source_select == SEL_LIVE |=>
      b_port_out == $past(a_port_in)) else $error("b port live data wrong");
   a_b_stored_path: assert property (ce && b_drive_enable && b_source_select == SEL_STORED |=>
      b_port_out == $past(a_stored_value)) else $error("b port stored data wrong");
   a_a_capture_load: assert property (a_edge |=> a_stored_value == $past(a_port_in) && a_captured)
      else $error("a register capture wrong");
   a_b_capture_load: assert property (b_edge |=> b_stored_value == $past(b_port_in) && b_captured)
      else $error("b register capture wrong");
   a_a_register_hold: assert property (!a_edge |=> $stable(a_stored_value))
      else $error("a register changed without capture");
   a_b_register_hold: assert property (!b_edge |=> $stable(b_stored_value))
      else $error("b register changed without capture");
   c_dual_load: cover property (a_edge && b_edge && !b_port_oe_n);
   c_both_stored: cover property (!a_port_oe_n && !b_port_oe_n && a_source_select && b_source_select);
   c_isolation: cover property (a_port_oe_n && b_port_oe_n && a_edge);
endmodule

bind obt_transceiver obt_transceiver_checker u_chk (.clk, .rst_n, .ce, .a_port_in, .a_port_out, .a_port_oe_n,
   .b_port_in, .b_port_out, .b_port_oe_n, .a_capture_clock, .b_capture_clock, .a_drive_enable_n,
   .b_drive_enable, .a_source_select, .b_source_select, .a_stored_value, .b_stored_value, .a_captured,
   .b_captured);

// >>> sim/obt_transceiver_test.sv
// obt_transceiver_test: self-checking bench for the octal transceiver
`timescale 1ns/10ps
module obt_transceiver_test;
   import obt_pkg::*;
   logic                 clk, rst_n, ce, log_ready, log_overflow_clear;
   logic [DATA_W-1:0]    a_line, b_line, a_port_out, b_port_out, a_stored_value, b_stored_value;
   logic [DATA_W-1:0]    a_agent_val, b_agent_val, ref_a, ref_b, va, vb, ea, eb;
   logic                 a_port_oe_n, b_port_oe_n, a_capture_clock, b_capture_clock, a_drive_enable_n;
   logic                 b_drive_enable, a_source_select, b_source_select, a_stored_valid, b_stored_valid;
   logic                 a_captured, b_captured, log_valid, log_in_ready, log_overflow, a_agent_en, b_agent_en;
   logic                 sa, sb, ca, cb;
   obt_mode_e            bus_mode;
   logic [LOG_W-1:0]     log_data;
   logic [LOG_CNT_W-1:0] log_level;
   int                   errors, total_checks, m;

   obt_transceiver u_dut (.clk, .rst_n, .ce, .a_port_in(a_line), .a_port_out, .a_port_oe_n, .b_port_in(b_line),
      .b_port_out, .b_port_oe_n, .a_capture_clock, .b_capture_clock, .a_drive_enable_n, .b_drive_enable,
      .a_source_select, .b_source_select, .a_stored_value, .b_stored_value, .a_stored_valid, .b_stored_valid,
      .a_captured, .b_captured, .bus_mode, .log_valid, .log_ready, .log_data, .log_level, .log_in_ready,
      .log_overflow, .log_overflow_clear);
   obt_bus_agent u_bus (.clk, .a_port_out, .a_port_oe_n, .b_port_out, .b_port_oe_n, .a_agent_en, .a_agent_val,
      .b_agent_en, .b_agent_val, .a_line, .b_line);

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic [DATA_W-1:0] pick(input logic sel, input logic [DATA_W-1:0] live, stored);
      return sel ? stored : live;
   endfunction
   task automatic check(input string what, input logic [LOG_W-1:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // outputs follow inputs one cycle late; two edges leaves margin for the far bus
   task automatic apply(input logic [3:0] ctl, input logic [1:0] ag, input logic [DATA_W-1:0] xa, xb);
      @(posedge clk);
      {a_drive_enable_n, b_drive_enable, a_source_select, b_source_select} <= ctl;
      {a_agent_en, b_agent_en} <= ag;
      a_agent_val <= xa;
      b_agent_val <= xb;
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic capture(input logic xa, xb);
      @(posedge clk);
      a_capture_clock <= xa;
      b_capture_clock <= xb;
      @(posedge clk);
      a_capture_clock <= 1'b0;
      b_capture_clock <= 1'b0;
      @(negedge clk);
      check("a_captured", a_captured, xa);
      check("b_captured", b_captured, xb);
   endtask

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      #200000;
      errors++;
      complete_run();
   end

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      {rst_n, ce, log_ready, log_overflow_clear, a_capture_clock, b_capture_clock} = 6'b011000;
      {a_drive_enable_n, b_drive_enable, a_source_select, b_source_select} = 4'b1000;
      {a_agent_en, b_agent_en, a_agent_val, b_agent_val} = 18'h30000;
      {ref_a, ref_b} = {DATA_RST, DATA_RST};
      void'($urandom(32'h53a6c30a));
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      check("a_stored_valid", a_stored_valid, 1'b0);
      check("b_stored_valid", b_stored_valid, 1'b0);
      for (int i = 0; i < 24; i++) begin
         m = $urandom_range(2);
         {sa, sb, ca, cb} = 4'($urandom);
         va = 8'($urandom);
         vb = 8'($urandom);
         apply({m != 2, m == 1, sa, sb}, {m != 2, m != 1}, va, vb);
         ea = (m == 2) ? pick(sa, vb, ref_b) : va;
         eb = (m == 1) ? pick(sb, va, ref_a) : vb;
         check("a_port_oe_n", a_port_oe_n, m != 2);
         check("b_port_oe_n", b_port_oe_n, m != 1);
         check("bus_mode", bus_mode, (m == 2) ? OBT_B_TO_A : (m == 1) ? OBT_A_TO_B : OBT_ISOLATE);
         check("a_line", a_line, ea);
         check("b_line", b_line, eb);
         // drop the b edge when a also captures and the driven port shows stored data
         if ((m == 1 && sb) || (m == 2 && sa))
            cb = cb & ~ca;
         capture(ca, cb);
         if (ca)
            ref_a = ea;
         if (cb)
            ref_b = eb;
         check("a_stored_value", a_stored_value, ref_a);
         check("b_stored_value", b_stored_value, ref_b);
      end
      apply(4'b1100, 2'b10, 8'h5a, 8'h00);
      capture(1'b1, 1'b1);
      check("a_stored_value", a_stored_value, 8'h5a);
      check("b_stored_value", b_stored_value, 8'h5a);
      check("a_stored_valid", a_stored_valid, 1'b1);
      check("b_stored_valid", b_stored_valid, 1'b1);
      apply(4'b0000, 2'b01, 8'h00, 8'ha5);
      capture(1'b1, 1'b1);
      check("a_stored_value", a_stored_value, 8'ha5);
      check("b_stored_value", b_stored_value, 8'ha5);
      apply(4'b1000, 2'b11, 8'h3c, 8'hc3);
      capture(1'b1, 1'b1);
      apply(4'b0111, 2'b00, 8'h00, 8'h00);
      check("a_line", a_line, 8'hc3);
      check("b_line", b_line, 8'h3c);
      check("bus_mode", bus_mode, OBT_BOTH_WAYS);
      apply(4'b0000, 2'b01, 8'h00, 8'h5a);
      @(posedge clk);
      a_source_select <= SEL_STORED;
      // whole word moves from live to stored in one clk edge
      for (int k = 0; k < 3; k++) begin
         @(negedge clk);
         check("a_line", a_line, (k == 0) ? 8'h5a : 8'hc3);
      end
      apply(4'b1100, 2'b10, 8'h96, 8'h00);
      apply(4'b0100, 2'b10, 8'h96, 8'h00);
      apply(4'b0100, 2'b00, 8'h00, 8'h00);
      check("a_line", a_line, 8'h96);
      check("b_line", b_line, 8'h96);
      // ce low: capture edges on the held lines must be ignored
      @(posedge clk);
      ce <= 1'b0;
      a_capture_clock <= 1'b1;
      b_capture_clock <= 1'b1;
      @(posedge clk);
      a_capture_clock <= 1'b0;
      b_capture_clock <= 1'b0;
      @(posedge clk);
      ce <= 1'b1;
      @(negedge clk);
      check("a_captured", a_captured, 1'b0);
      check("a_stored_value", a_stored_value, 8'h3c);
      check("b_stored_value", b_stored_value, 8'hc3);
      // log fifo: fill past full with the reader stalled, then drain
      apply(4'b1000, 2'b11, 8'h00, 8'h00);
      @(posedge clk);
      log_ready <= 1'b0;
      for (int k = 0; k < 9; k++) begin
         @(posedge clk);
         a_agent_val <= 8'(k);
         capture(1'b1, 1'b0);
      end
      check("log_level", log_level, CNT_FULL);
      check("log_in_ready", log_in_ready, 1'b0);
      check("log_overflow", log_overflow, 1'b1);
      check("log_data", log_data, 18'h10000);
      @(posedge clk);
      log_overflow_clear <= 1'b1;
      @(posedge clk);
      log_overflow_clear <= 1'b0;
      @(negedge clk);
      check("log_overflow", log_overflow, 1'b0);
      repeat (60) begin
         @(posedge clk);
         log_ready <= 1'($urandom);
      end
      @(negedge clk);
      check("log_level", log_level, CNT_RST);
      check("log_valid", log_valid, 1'b0);
      complete_run();
   end
endmodule
